/* design/dch_pkg.sv */
// package: constants and types for the debug channel handshake block
package dch_pkg;
  // software register selects
  typedef enum logic [1:0] {
    DCH_SEL_CTRL = 2'h0,
    DCH_SEL_TX = 2'h1,
    DCH_SEL_RX = 2'h2,
    DCH_SEL_NONE = 2'h3
  } dch_sel_t;
  // handshake control word bit positions
  localparam int DCH_BIT_RXRDY = 31;
  localparam int DCH_BIT_OVF = 30;
  localparam int DCH_BIT_DL = 29;
  localparam int DCH_BIT_TXRDY = 28;
  // reset values of the flags
  localparam logic DCH_RST_RXRDY = 1'h0;
  localparam logic DCH_RST_OVF = 1'h0;
  localparam logic DCH_RST_DL = 1'h0;
  localparam logic DCH_RST_TXRDY = 1'h0;
  // scan chain layout
  localparam int DCH_SR_W = 36;
  localparam int DCH_SR_FLAG = 0;
  localparam int DCH_SR_VALID = 2;
  localparam int DCH_SR_DATA_LO = 3;
  localparam int DCH_SR_DATA_HI = 34;
  localparam int DCH_SR_DL = 35;
  // link input bundle positions
  localparam int DCH_IN_W = 8;
  localparam int DCH_IN_TCK = 0;
  localparam int DCH_IN_SELRX = 1;
  localparam int DCH_IN_SELTX = 2;
  localparam int DCH_IN_CAP = 3;
  localparam int DCH_IN_SHIFT = 4;
  localparam int DCH_IN_UPD = 5;
  localparam int DCH_IN_TDI = 6;
  localparam int DCH_IN_TRSTN = 7;
  localparam logic [DCH_IN_W-1:0] DCH_IN_RST = 8'h80;
endpackage

/* design/dch_handshake.sv */
// module: debug channel handshake flags, transmit and receive registers
`timescale 1ns/100ps
// What this block does
// - a valid debugger load of the receive register sets receive-ready
// - handler polls receive-ready, reads receive register; that read clears receive-ready
// - a valid word with the download bit sets receive-ready and the download flag
// - debugger load while receive-ready is set raises sticky overflow, bit 30
// - overflow stays set until software writes the control word with bit 30 clear
// - download flag, bit 29, is set only from the link; software writes ignored
// - debugger clears download flag after last word; handler loops until it clears
// - handler writes transmit only when ready clear; that write sets bit 28
// - scanning out data while transmit-ready is set clears transmit-ready
// - flags sit in bits 31 to 28 so a read lands on the condition flags
// - transmit register is 32 bits, software read/write, link read-only, no reset
// - receive register buffers words from the debugger to the handler
// - receive register loads only with valid set and receive-ready clear
module dch_handshake (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sw_rd_in,
  input wire logic sw_wr_in,
  input wire dch_pkg::dch_sel_t sw_sel_in,
  input wire logic [31:0] sw_wdata_in,
  output logic [31:0] sw_rdata_out,
  output logic sw_rvalid_out,
  input wire logic jtag_tck_in,
  input wire logic jtag_trstn_in,
  input wire logic jtag_sel_rx_in,
  input wire logic jtag_sel_tx_in,
  input wire logic jtag_capture_in,
  input wire logic jtag_shift_in,
  input wire logic jtag_update_in,
  input wire logic jtag_tdi_in,
  output logic jtag_tdo_out
);
  import dch_pkg::*;

  function automatic logic sw_hit(input logic strobe, input dch_sel_t sel, input dch_sel_t want);
    sw_hit = strobe && (sel == want);
  endfunction

  // ----------------------------------------------------------------
  // link input sampling
  // ----------------------------------------------------------------
  logic [DCH_IN_W-1:0] raw;
  logic [DCH_IN_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic tck_prev_r;
  assign raw = {jtag_trstn_in, jtag_tdi_in, jtag_update_in, jtag_shift_in,
                jtag_capture_in, jtag_sel_tx_in, jtag_sel_rx_in, jtag_tck_in};

  // a bit only moves once the second and third stages agree, filtering slow edges
  genvar gi;
  generate
    for (gi = 0; gi < DCH_IN_W; gi++) begin : g_filt
      always_comb begin
        filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_r <= DCH_IN_RST;
      s2_r <= DCH_IN_RST;
      s3_r <= DCH_IN_RST;
      filt_r <= DCH_IN_RST;
      tck_prev_r <= 1'b0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      tck_prev_r <= filt_r[DCH_IN_TCK];
    end
  end

  logic tck_rise, trst_act, sel_rx, sel_tx, do_cap, do_shift, do_upd;
  assign tck_rise = filt_r[DCH_IN_TCK] && !tck_prev_r;
  assign trst_act = !filt_r[DCH_IN_TRSTN];
  assign sel_rx = filt_r[DCH_IN_SELRX];
  assign sel_tx = filt_r[DCH_IN_SELTX];
  assign do_cap = tck_rise && filt_r[DCH_IN_CAP] && (sel_rx || sel_tx);
  assign do_shift = tck_rise && filt_r[DCH_IN_SHIFT] && (sel_rx || sel_tx);
  assign do_upd = tck_rise && filt_r[DCH_IN_UPD];

  // ----------------------------------------------------------------
  // flags, registers and scan chain
  // ----------------------------------------------------------------
  logic rxrdy_r, rxrdy_nxt, ovf_r, ovf_nxt, dl_r, dl_nxt, txrdy_r, txrdy_nxt;
  logic txcap_r, txcap_nxt;
  logic [31:0] tx_r, tx_nxt, rx_r, rx_nxt;
  logic [DCH_SR_W-1:0] sr_r, sr_nxt;
  logic [31:0] rdata_nxt;
  logic rx_load, rx_take, sw_rx_rd, sw_ctrl_wr, sw_tx_wr, txrdy_clr;
  logic [31:0] ctrl_word;

  // each flag at its own position so one read lands on the condition flags
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[DCH_BIT_RXRDY] = rxrdy_r;
    ctrl_word[DCH_BIT_OVF] = ovf_r;
    ctrl_word[DCH_BIT_DL] = dl_r;
    ctrl_word[DCH_BIT_TXRDY] = txrdy_r;
  end
  assign sw_rx_rd = sw_hit(sw_rd_in, sw_sel_in, DCH_SEL_RX);
  assign sw_ctrl_wr = sw_hit(sw_wr_in, sw_sel_in, DCH_SEL_CTRL);
  assign sw_tx_wr = sw_hit(sw_wr_in, sw_sel_in, DCH_SEL_TX);
  assign rx_load = do_upd && sel_rx && sr_r[DCH_SR_VALID];
  assign rx_take = rx_load && !rxrdy_r;
  // first shift after capturing a set ready bit means the word was read out
  assign txrdy_clr = do_shift && sel_tx && txcap_r;

  always_comb begin
    rxrdy_nxt = rxrdy_r;
    ovf_nxt = ovf_r;
    dl_nxt = dl_r;
    txrdy_nxt = txrdy_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    sr_nxt = sr_r;
    txcap_nxt = txcap_r;
    rdata_nxt = sw_rdata_out;
    if (sw_rx_rd) begin
      rxrdy_nxt = 1'b0;
    end
    if (sw_ctrl_wr) begin
      ovf_nxt = sw_wdata_in[DCH_BIT_OVF];
    end
    if (txrdy_clr) begin
      txrdy_nxt = 1'b0;
    end
    if (sw_tx_wr) begin
      tx_nxt = sw_wdata_in;
      txrdy_nxt = 1'b1;
    end
    // a link event lands after the software clear so the set wins
    if (rx_load) begin
      rxrdy_nxt = 1'b1;
      dl_nxt = sr_r[DCH_SR_DL];
      if (rxrdy_r) begin
        ovf_nxt = 1'b1;
      end
    end
    if (rx_take) begin
      rx_nxt = sr_r[DCH_SR_DATA_HI:DCH_SR_DATA_LO];
    end
    if (do_cap) begin
      sr_nxt = '0;
      if (sel_tx) begin
        sr_nxt[DCH_SR_DATA_HI:DCH_SR_DATA_LO] = tx_r;
        sr_nxt[DCH_SR_FLAG] = txrdy_r;
        txcap_nxt = txrdy_r;
      end else begin
        sr_nxt[DCH_SR_FLAG] = rxrdy_r;
      end
    end else if (do_shift) begin
      sr_nxt = {filt_r[DCH_IN_TDI], sr_r[DCH_SR_W-1:1]};
      txcap_nxt = 1'b0;
    end
    // test reset clears receive-ready, download and txcap_r, leaves the rest
    if (trst_act) begin
      rxrdy_nxt = DCH_RST_RXRDY;
      dl_nxt = DCH_RST_DL;
      txcap_nxt = 1'b0;
    end
    rdata_nxt = 32'h00000000;
    case (sw_sel_in)
      DCH_SEL_CTRL: rdata_nxt = ctrl_word;
      DCH_SEL_TX: rdata_nxt = tx_r;
      DCH_SEL_RX: rdata_nxt = rx_r;
      default: rdata_nxt = 32'h00000000;
    endcase
    if (!sw_rd_in) begin
      rdata_nxt = sw_rdata_out;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rxrdy_r <= DCH_RST_RXRDY;
      ovf_r <= DCH_RST_OVF;
      dl_r <= DCH_RST_DL;
      txrdy_r <= DCH_RST_TXRDY;
      txcap_r <= 1'b0;
      sr_r <= '0;
      sw_rdata_out <= 32'h00000000;
      sw_rvalid_out <= 1'b0;
      jtag_tdo_out <= 1'b0;
    end else begin
      rxrdy_r <= rxrdy_nxt;
      ovf_r <= ovf_nxt;
      dl_r <= dl_nxt;
      txrdy_r <= txrdy_nxt;
      txcap_r <= txcap_nxt;
      sr_r <= sr_nxt;
      sw_rdata_out <= rdata_nxt;
      sw_rvalid_out <= sw_rd_in;
      jtag_tdo_out <= sr_nxt[0];
    end
  end

  // data registers keep no reset: contents undefined after reset
  always_ff @(posedge clk_in) begin
    tx_r <= tx_nxt;
    rx_r <= rx_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_tx_write_sets: assert property (sw_tx_wr
    |=> txrdy_r && tx_r == $past(sw_wdata_in))
    else $error("transmit write did not set ready");
  a_rx_load_sets: assert property (rx_load && !trst_act |=> rxrdy_r)
    else $error("receive load did not set ready");
  a_dl_follows: assert property (rx_load && !trst_act
    |=> dl_r == $past(sr_r[DCH_SR_DL]))
    else $error("download flag not loaded");
  // receive data has no reset, so hold checks use case equality
  a_ovf_on_full: assert property (rx_load && rxrdy_r
    |=> ovf_r && rx_r === $past(rx_r))
    else $error("overflow not flagged or data overwritten");
  a_ovf_sticky: assert property (ovf_r && !sw_ctrl_wr |=> ovf_r)
    else $error("overflow dropped without a control write");
  a_dl_sw_ro: assert property (!rx_load && !trst_act |=> dl_r == $past(dl_r))
    else $error("download flag moved without the link");
  a_rxrdy_rd_clear: assert property (sw_rx_rd && !rx_load |=> !rxrdy_r)
    else $error("receive read did not clear ready");
  a_rx_hold: assert property (!rx_take |=> rx_r === $past(rx_r))
    else $error("receive register changed without a valid load");
  a_txrdy_scan_clear: assert property (txrdy_clr && !sw_tx_wr |=> !txrdy_r)
    else $error("scan out did not clear transmit ready");
  a_ctrl_map: assert property (sw_hit(sw_rd_in, sw_sel_in, DCH_SEL_CTRL)
    |=> sw_rvalid_out && sw_rdata_out[31:28] == $past({rxrdy_r, ovf_r, dl_r, txrdy_r}))
    else $error("control word flags misplaced");

  c_normal_rx: cover property (rx_take ##[1:50] sw_rx_rd);
  c_overflow: cover property (rx_load && rxrdy_r);
  c_tx_round: cover property (sw_tx_wr ##[1:400] txrdy_clr);
  c_download: cover property (rx_load && sr_r[DCH_SR_DL]);
endmodule

/* bench/dch_dbg_model.sv */
// partner: behavioural link debugger that runs whole scan frames
`timescale 1ns/100ps
module dch_dbg_model (
  output logic tck_out,
  output logic trstn_out,
  output logic sel_rx_out,
  output logic sel_tx_out,
  output logic cap_out,
  output logic shift_out,
  output logic upd_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // tck stands low between frames; levels move only while tck is low
  initial begin
    {tck_out, sel_rx_out, sel_tx_out, cap_out, shift_out, upd_out, tdi_out} = '0;
    trstn_out = 1'b1;
  end
  task automatic tick();
    #80 tck_out = 1'b1;
    #80 tck_out = 1'b0;
  endtask
  // callers poll ready before valid words, or stream without polling
  task automatic scan(input logic rx, input logic [35:0] din,
                      output logic [35:0] dout);
    sel_rx_out = rx;
    sel_tx_out = !rx;
    cap_out = 1'b1;
    tick();
    cap_out = 1'b0;
    shift_out = 1'b1;
    for (int i = 0; i < 36; i++) begin
      tdi_out = din[i];
      #79 dout[i] = tdo_in;
      #1 tck_out = 1'b1;
      #80 tck_out = 1'b0;
    end
    shift_out = 1'b0;
    tdi_out = !tdi_out; // released: never the stale bit
    upd_out = 1'b1;
    tick();
    {upd_out, sel_rx_out, sel_tx_out} = '0;
    #80;
  endtask
  task automatic reset_link();
    trstn_out = 1'b0;
    #400 trstn_out = 1'b1;
    #200;
  endtask
endmodule

/* bench/test_debug_comm_channel_handshake.sv */
// testbench: software and link traffic through the handshake block
`timescale 1ns/100ps
module test_debug_comm_channel_handshake;
  import dch_pkg::*;
  typedef struct {logic [35:0] w; logic [31:0] ctrl; logic [31:0] rx;} dch_row_t;
  logic clk_in, resetn_in, rd_s, wr_s, rvalid, tdo;
  logic tck, trstn, srx, stx, cap, sh, upd, tdi;
  dch_sel_t sel;
  logic [31:0] wdata, rdata, r;
  logic [35:0] so;
  int fails, n_compared;
  dch_row_t rows [4] = '{
    '{{1'b0, 32'h1111_2222, 1'b1, 2'h0}, 32'h8000_0000, 32'h1111_2222},
    '{{1'b1, 32'h3333_4444, 1'b0, 2'h0}, 32'h0000_0000, 32'h1111_2222},
    '{{1'b1, 32'h5555_6666, 1'b1, 2'h0}, 32'ha000_0000, 32'h5555_6666},
    '{{1'b0, 32'h7777_8888, 1'b1, 2'h0}, 32'h8000_0000, 32'h7777_8888}};
  dch_handshake dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .sw_rd_in(rd_s),
    .sw_wr_in(wr_s), .sw_sel_in(sel), .sw_wdata_in(wdata), .sw_rdata_out(rdata),
    .sw_rvalid_out(rvalid), .jtag_tck_in(tck), .jtag_trstn_in(trstn),
    .jtag_sel_rx_in(srx), .jtag_sel_tx_in(stx), .jtag_capture_in(cap),
    .jtag_shift_in(sh), .jtag_update_in(upd), .jtag_tdi_in(tdi), .jtag_tdo_out(tdo));
  dch_dbg_model dbg_u (.tck_out(tck), .trstn_out(trstn), .sel_rx_out(srx),
    .sel_tx_out(stx), .cap_out(cap), .shift_out(sh), .upd_out(upd), .tdi_out(tdi),
    .tdo_in(tdo));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_sw(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t sw read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_scan(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t scan out %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input dch_sel_t s, input logic [31:0] d);
    @(posedge clk_in) #1;
    {sel, wdata, wr_s} = {s, d, 1'b1};
    @(posedge clk_in) #1;
    {sel, wr_s} = {DCH_SEL_NONE, 1'b0};
  endtask
  // a missing valid pulse turns the result unknown so the compare fails
  task automatic rd(input dch_sel_t s, output logic [31:0] d);
    @(posedge clk_in) #1;
    {sel, rd_s} = {s, 1'b1};
    @(posedge clk_in) #1;
    {sel, rd_s} = {DCH_SEL_NONE, 1'b0};
    d = (rvalid === 1'b1) ? rdata : 'x;
  endtask
  initial begin
    // longest path is about 14 frames of 6.2 us; generous margin
    #600000;
    fails++;
    final_report();
  end
  initial begin
    {resetn_in, rd_s, wr_s, wdata, sel} = {1'b0, 1'b0, 1'b0, 32'h0, DCH_SEL_NONE};
    repeat (6) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h0);
    rd(DCH_SEL_NONE, r);
    chk_sw(r, 32'h0);
    for (int k = 0; k < 4; k++) begin
      dbg_u.scan(1'b1, 36'h0, so);
      chk_scan(so, 36'h0);
      dbg_u.scan(1'b1, rows[k].w, so);
      rd(DCH_SEL_CTRL, r);
      chk_sw(r, rows[k].ctrl);
      rd(DCH_SEL_RX, r);
      chk_sw(r, rows[k].rx);
      rd(DCH_SEL_CTRL, r);
      chk_sw(r, rows[k].ctrl & 32'h7fff_ffff);
    end
    // streaming without a read in between must overflow
    dbg_u.scan(1'b1, {1'b1, 32'haaaa_5555, 1'b1, 2'h0}, so);
    dbg_u.scan(1'b1, {1'b1, 32'h5555_aaaa, 1'b1, 2'h0}, so);
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'he000_0000);
    rd(DCH_SEL_RX, r);
    chk_sw(r, 32'haaaa_5555);
    wr(DCH_SEL_CTRL, 32'hffff_ffff);
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h6000_0000);
    wr(DCH_SEL_CTRL, 32'h0);
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h2000_0000);
    dbg_u.scan(1'b1, {1'b0, 32'h0, 1'b1, 2'h0}, so);
    rd(DCH_SEL_RX, r);
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h0);
    // transmit path; update on the transmit chain must do nothing
    wr(DCH_SEL_TX, 32'hc3a5_0f96);
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h1000_0000);
    rd(DCH_SEL_TX, r);
    chk_sw(r, 32'hc3a5_0f96);
    dbg_u.scan(1'b0, {1'b1, 32'hffff_ffff, 1'b1, 2'h3}, so);
    chk_scan(so, {1'b0, 32'hc3a5_0f96, 3'h1});
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h0);
    dbg_u.scan(1'b0, 36'h0, so);
    chk_scan(so, {1'b0, 32'hc3a5_0f96, 3'h0});
    // test reset clears receive-ready and download only
    wr(DCH_SEL_TX, 32'h0f0f_1234);
    dbg_u.scan(1'b1, {1'b1, 32'h1, 1'b1, 2'h0}, so);
    dbg_u.reset_link();
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h1000_0000);
    rd(DCH_SEL_TX, r);
    chk_sw(r, 32'h0f0f_1234);
    // mid-run reset returns flags and the read port to idle
    wr(DCH_SEL_CTRL, 32'h4000_0000);
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h5000_0000);
    @(posedge clk_in) #1;
    resetn_in = 1'b0;
    @(posedge clk_in) #1;
    chk_sw({rdata[31:1], rdata[0] | rvalid}, 32'h0);
    @(posedge clk_in) #1;
    resetn_in = 1'b1;
    rd(DCH_SEL_CTRL, r);
    chk_sw(r, 32'h0);
    final_report();
  end
endmodule
